// file: dv/erase_suspend_and_otp_access_control_bench.sv
// Purpose: register-level tests of erase suspend and otp access
// Assumes: zero-wait apb, prdata valid in the access phase
// Notes:   suspend count shortened to 4 cycles
`timescale 1ns/1ps
`include "erase_otp_defs.svh"
module erase_suspend_and_otp_access_control_bench;
   localparam int SUSP = 4;
   logic        sys_clk;
   logic        rst = 1'b1;
   logic        done;
   logic        fail;
   logic        fail_en = 1'b0;
   logic        erase;
   logic        prog;
   logic        otp_sel;
   logic [15:0] lock_word = 16'h00fc;
   logic [15:0] blk;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   logic [15:0] rst_codes [3] = '{`CMD_CORE_RST, `CMD_WARM_RST, `CMD_HOT_RST};
   int          bad_count = 0;
   int          checks_done = 0;

   erase_otp_ctrl #(.SUSPEND_CYCLES(SUSP)) dut_u (
      .sys_clk_i(sys_clk), .rst_i(rst), .lock_word_i(lock_word),
      .core_done_i(done), .core_fail_i(fail), .core_erase_o(erase),
      .core_program_o(prog), .core_otp_sel_o(otp_sel),
      .array_block_address_o(blk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   flash_core_model core_u (
      .sys_clk_i(sys_clk), .rst_i(rst), .erase_i(erase), .program_i(prog),
      .fail_en_i(fail_en), .done_o(done), .fail_o(fail));

   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // entered right after a rising edge; read data lands in rd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic do_reset(input logic [15:0] lw);
      lock_word <= lw;
      rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic wait_erase_end();
      for (int i = 0; i < 100 && (erase !== 1'b0 || prog !== 1'b0); i++)
         @(posedge sys_clk);
      apb(1'b0, `REG_STATUS, 32'h0);
   endtask

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      final_report();
   end

   initial
   begin
      do_reset(16'h00fc);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[6], 1'b1);
      chk(rd[5], 1'b0);
      apb(1'b1, `REG_ADDR, 32'h0123);
      apb(1'b1, `REG_CMD, `CMD_ERASE);
      chk(erase, 1'b1);
      chk(blk, 16'h0123);
      apb(1'b1, `REG_CMD, `CMD_OTP);
      chk(otp_sel, 1'b0);
      // suspend only once the erase runs, never while addresses latch
      apb(1'b1, `REG_CMD, `CMD_SUSPEND);
      repeat (SUSP) @(posedge sys_clk);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[4], 1'b1);
      chk(erase, 1'b0);
      apb(1'b1, `REG_CMD, `CMD_ERASE);
      chk(erase, 1'b0);
      apb(1'b1, `REG_CMD, `CMD_MB_ERASE);
      apb(1'b1, `REG_CMD, `CMD_SUSPEND);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[4], 1'b1);
      // the moved address points away from the suspended block
      apb(1'b1, `REG_ADDR, 32'h0055);
      apb(1'b1, `REG_CMD, `CMD_VERIFY);
      apb(1'b1, `REG_CMD, `CMD_OTP);
      chk(otp_sel, 1'b1);
      apb(1'b1, `REG_CMD, `CMD_CORE_RST);
      chk(otp_sel, 1'b0);
      apb(1'b1, `REG_CMD, `CMD_PROGRAM);
      chk(prog, 1'b1);
      chk(blk, 16'h0055);
      wait_erase_end();
      chk(rd[4], 1'b1);
      chk(rd[15], 1'b0);
      // the moved address must not steer the resumed erase
      apb(1'b1, `REG_CMD, `CMD_RESUME);
      chk(erase, 1'b1);
      chk(blk, 16'h0123);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[4], 1'b0);
      wait_erase_end();
      chk(rd[15], 1'b0);
      chk(rd[10], 1'b0);
      apb(1'b1, `REG_ADDR, 32'h0123);
      apb(1'b1, `REG_CMD, `CMD_VERIFY);
      chk(erase, 1'b0);
      $display("test erase_suspend_resume done");
      apb(1'b1, `REG_ADDR, 32'h0010);
      apb(1'b1, `REG_CMD, `CMD_MB_ERASE);
      apb(1'b1, `REG_ADDR, 32'h0011);
      apb(1'b1, `REG_CMD, `CMD_MB_ERASE);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[15], 1'b1);
      chk(erase, 1'b0);
      apb(1'b1, `REG_ADDR, 32'h0012);
      apb(1'b1, `REG_CMD, `CMD_ERASE);
      chk(blk, 16'h0010);
      apb(1'b1, `REG_CMD, `CMD_SUSPEND);
      repeat (SUSP) @(posedge sys_clk);
      apb(1'b1, `REG_CMD, `CMD_RESUME);
      chk(erase, 1'b1);
      chk(blk, 16'h0010);
      wait_erase_end();
      chk(rd[15], 1'b0);
      $display("test multi_block_erase done");
      apb(1'b1, `REG_CMD, `CMD_OTP);
      chk(otp_sel, 1'b1);
      apb(1'b1, `REG_CMD, `CMD_PROGRAM);
      chk(prog, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[10], 1'b1);
      chk(rd[3], 1'b1);
      foreach (rst_codes[k])
      begin
         apb(1'b1, `REG_CMD, `CMD_OTP);
         chk(otp_sel, 1'b1);
         apb(1'b1, `REG_CMD, {16'h0000, rst_codes[k]});
         chk(otp_sel, 1'b0);
      end
      apb(1'b0, 12'hff0, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(err, 1'b0);
      $display("test otp_access done");
      apb(1'b1, `REG_CMD, `CMD_OTP);
      do_reset(16'h00f0);
      chk(otp_sel, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[6:5], 2'b11);
      fail_en <= 1'b1;
      apb(1'b1, `REG_ADDR, 32'h0200);
      apb(1'b1, `REG_CMD, `CMD_ERASE);
      wait_erase_end();
      chk(rd[10], 1'b1);
      $display("test lock_and_fail done");
      fail_en <= 1'b0;
      do_reset(16'h00ff);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[6:5], 2'b00);
      apb(1'b1, `REG_CMD, `CMD_OTP);
      apb(1'b1, `REG_ADDR, 32'h0300);
      apb(1'b1, `REG_PAGE, 32'h0031);
      apb(1'b0, `REG_PAGE, 32'h0);
      chk(rd, 32'h0000_0031);
      apb(1'b1, `REG_CMD, `CMD_PROGRAM);
      chk(prog, 1'b1);
      chk(otp_sel, 1'b1);
      wait_erase_end();
      chk(rd[10], 1'b0);
      apb(1'b1, `REG_PAGE, 32'h0032);
      apb(1'b1, `REG_CMD, `CMD_PROGRAM);
      chk(prog, 1'b0);
      apb(1'b0, `REG_STATUS, 32'h0);
      chk(rd[10], 1'b1);
      $display("test otp_program done");
      final_report();
   end
endmodule

// file: dv/flash_core_model.sv
// Purpose: behavioural flash core answering erase and program requests
// Assumes: requests are levels held until done is seen
// Notes:   count restarts when a request drops, so a resumed erase runs in full
`timescale 1ns/1ps
module flash_core_model #(
   parameter int BUSY_CYCLES = 30
)(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // requests from the sequencer
   input  wire logic erase_i,
   input  wire logic program_i,
   input  wire logic fail_en_i,
   // answers
   output logic      done_o,
   output logic      fail_o
);
   int count_reg;
   assign done_o = (count_reg == BUSY_CYCLES);
   assign fail_o = done_o & fail_en_i;
   always_ff @(posedge sys_clk_i)
   begin
      // a dropped request throws away progress
      if (rst_i || !(erase_i || program_i) || done_o)
         count_reg <= 0;
      else
         count_reg <= count_reg + 1;
   end
endmodule

// file: hw/erase_otp_ctrl.sv
// Purpose: erase suspend/resume and otp access sequencer behind an apb slave
// Assumes: core_done_i pulses when the flash core finishes an erase or program
// Notes:   suspend latency is counted internally, bounded by the 500 us limit
`timescale 1ns/1ps
`include "erase_otp_defs.svh"
module erase_otp_ctrl #(
   parameter int SUSPEND_CYCLES = (`SUSPEND_US * `CLK_MHZ) / 4
)(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // power-up lock word from the otp array
   input  wire logic [15:0] lock_word_i,
   // flash core handshake
   input  wire logic        core_done_i,
   input  wire logic        core_fail_i,
   output logic             core_erase_o,
   output logic             core_program_o,
   output logic             core_otp_sel_o,
   output logic [15:0]      array_block_address_o,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   localparam int SUSPEND_MAX = `SUSPEND_US * `CLK_MHZ;
   // a zero latency never reaches suspended, a long one breaks the bound
   if (SUSPEND_CYCLES < 1 || SUSPEND_CYCLES > SUSPEND_MAX)
   begin : bad_suspend_cycles
      $error("suspend latency out of range");
   end

   erase_otp_pkg::seq_state_type state_reg, state_next;
   logic [15:0] addr_reg, addr_next;
   logic [15:0] erase_addr_reg, erase_addr_next;
   logic [5:0]  page_reg, page_next;
   logic        mb_reg, mb_next;
   logic        otp_mode_reg, otp_mode_next;
   logic        otp_lock_reg, otp_lock_next;
   logic        first_block_locked_flag_reg, first_block_locked_flag_next;
   logic        err_reg, err_next;
   logic        susp_flag_reg, susp_flag_next;
   logic        boot_reg, boot_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [31:0] rdata_reg, rdata_next;

   wire         acc = psel && penable;
   wire         wr  = acc && pwrite;
   wire         cmd_wr = wr && paddr == `REG_CMD;
   wire [15:0]  cmd = pwdata[15:0];
   wire         busy = state_reg == erase_otp_pkg::ERASING
                    || state_reg == erase_otp_pkg::SUSPENDING
                    || state_reg == erase_otp_pkg::PROGRAMMING;

   assign pready  = 1'b1;
   assign pslverr = acc && !(paddr == `REG_CMD || paddr == `REG_ADDR
                    || paddr == `REG_STATUS || paddr == `REG_LOCKWORD
                    || paddr == `REG_PAGE);
   assign prdata  = rdata_reg;

   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      erase_addr_next = erase_addr_reg;
      page_next = page_reg;
      mb_next = mb_reg;
      otp_mode_next = otp_mode_reg;
      otp_lock_next = otp_lock_reg;
      first_block_locked_flag_next = first_block_locked_flag_reg;
      err_next = err_reg;
      susp_flag_next = susp_flag_reg;
      boot_next = 1'b0;
      cnt_next = cnt_reg;
      rdata_next = 32'h0000_0000;
      // lock word sampled once after reset release, so a strap level is never
      // loaded through the reset path
      if (boot_reg)
      begin
         otp_lock_next = lock_word_i[7:0] == `LOCK_PATTERN
                      || lock_word_i[7:0] == `LOCK_BOTH;
         first_block_locked_flag_next = lock_word_i[7:0] == `LOCK_BOTH;
      end
      if (wr && paddr == `REG_ADDR && !busy)
         addr_next = pwdata[15:0];
      if (wr && paddr == `REG_PAGE && !busy)
         page_next = pwdata[5:0];
      // read data is loaded in the setup cycle so that it already stands
      // when pready is sampled in the access phase
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            `REG_ADDR:     rdata_next = {16'h0000, addr_reg};
            `REG_PAGE:     rdata_next = {26'h0000000, page_reg};
            `REG_LOCKWORD: rdata_next = {16'h0000, lock_word_i};
            `REG_STATUS:
            begin
               rdata_next[`ST_ONGO] = busy || state_reg == erase_otp_pkg::MB_LATCH;
               rdata_next[`ST_ERROR] = err_reg;
               rdata_next[`ST_OTP_LOCK] = otp_lock_reg;
               rdata_next[`ST_FIRST_LOCK] = first_block_locked_flag_reg;
               rdata_next[`ST_SUSPENDED] = susp_flag_reg;
               rdata_next[`ST_OTP_MODE] = otp_mode_reg;
            end
            default:       rdata_next = 32'h0000_0000;
         endcase
      end
      // core, hot and warm resets drop otp mode; the suspended erase survives
      if (cmd_wr && (cmd == `CMD_CORE_RST || cmd == `CMD_HOT_RST
          || cmd == `CMD_WARM_RST))
         otp_mode_next = 1'b0;
      case (state_reg)
         erase_otp_pkg::IDLE, erase_otp_pkg::MB_LATCH, erase_otp_pkg::SUSPENDED:
         begin
            if (cmd_wr)
            begin
               err_next = 1'b0;
               case (cmd)
                  `CMD_MB_ERASE:
                     if (!susp_flag_reg && !otp_mode_reg)
                     begin
                        state_next = erase_otp_pkg::MB_LATCH;
                        mb_next = 1'b1;
                        if (state_reg == erase_otp_pkg::IDLE)
                           erase_addr_next = addr_reg;
                     end
                  `CMD_ERASE:
                     if (!susp_flag_reg && !otp_mode_reg)
                     begin
                        state_next = erase_otp_pkg::ERASING;
                        if (state_reg == erase_otp_pkg::IDLE)
                        begin
                           erase_addr_next = addr_reg;
                           mb_next = 1'b0;
                        end
                     end
                  `CMD_RESUME:
                     if (susp_flag_reg)
                     begin
                        // restart from the first latched block, address ignored
                        state_next = erase_otp_pkg::ERASING;
                        susp_flag_next = 1'b0;
                     end
                  `CMD_OTP:
                     otp_mode_next = 1'b1;
                  `CMD_PROGRAM:
                     // manufacturer pages above the user area are never host programmed
                     if (otp_mode_reg && (otp_lock_reg || page_reg > `OTP_USER_LAST))
                        err_next = 1'b1;
                     else
                        state_next = erase_otp_pkg::PROGRAMMING;
                  default:
                     state_next = state_reg;
               endcase
               // another command aborts an address latch sequence
               if (state_reg == erase_otp_pkg::MB_LATCH && cmd != `CMD_MB_ERASE
                   && cmd != `CMD_ERASE)
                  state_next = erase_otp_pkg::IDLE;
            end
         end
         erase_otp_pkg::ERASING:
         begin
            // only suspend is taken here; address register is not looked at
            if (cmd_wr && cmd == `CMD_SUSPEND)
            begin
               state_next = erase_otp_pkg::SUSPENDING;
               cnt_next = 32'h0000_0000;
            end
            else if (core_done_i)
            begin
               state_next = erase_otp_pkg::IDLE;
               err_next = core_fail_i;
            end
         end
         erase_otp_pkg::SUSPENDING:
         begin
            cnt_next = cnt_reg + 32'h0000_0001;
            if (cnt_reg >= SUSPEND_CYCLES - 1)
            begin
               state_next = erase_otp_pkg::SUSPENDED;
               susp_flag_next = 1'b1;
            end
         end
         erase_otp_pkg::PROGRAMMING:
            if (core_done_i)
            begin
               state_next = susp_flag_reg ? erase_otp_pkg::SUSPENDED
                                          : erase_otp_pkg::IDLE;
               err_next = core_fail_i;
            end
         default:
            state_next = erase_otp_pkg::IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= erase_otp_pkg::IDLE;
         addr_reg <= 16'h0000;
         erase_addr_reg <= 16'h0000;
         page_reg <= 6'h00;
         mb_reg <= 1'b0;
         otp_mode_reg <= 1'b0;
         otp_lock_reg <= 1'b0;
         first_block_locked_flag_reg <= 1'b0;
         err_reg <= 1'b0;
         susp_flag_reg <= 1'b0;
         boot_reg <= 1'b1;
         cnt_reg <= 32'h0000_0000;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         erase_addr_reg <= erase_addr_next;
         page_reg <= page_next;
         mb_reg <= mb_next;
         otp_mode_reg <= otp_mode_next;
         otp_lock_reg <= otp_lock_next;
         first_block_locked_flag_reg <= first_block_locked_flag_next;
         err_reg <= err_next;
         susp_flag_reg <= susp_flag_next;
         boot_reg <= boot_next;
         cnt_reg <= cnt_next;
         rdata_reg <= rdata_next;
      end
   end

   assign core_erase_o   = state_reg == erase_otp_pkg::ERASING;
   assign core_program_o = state_reg == erase_otp_pkg::PROGRAMMING;
   assign core_otp_sel_o = otp_mode_reg;
   // erase address is held so resume starts over; otp program never erases
   assign array_block_address_o = core_erase_o ? erase_addr_reg : addr_reg;

   chk_suspend_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::SUSPENDING |-> cnt_reg < SUSPEND_CYCLES)
      else $error("suspend took too long");
   chk_no_erase_susp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      susp_flag_reg && cmd_wr && cmd == `CMD_ERASE |=> state_reg != erase_otp_pkg::ERASING)
      else $error("erase accepted while suspended");
   chk_resume_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::SUSPENDED && cmd_wr && cmd == `CMD_RESUME
      |=> !susp_flag_reg && state_reg == erase_otp_pkg::ERASING)
      else $error("resume not taken");
   chk_locked_prog: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::IDLE && cmd_wr && cmd == `CMD_PROGRAM
      && otp_mode_reg && otp_lock_reg |=> err_reg && !core_program_o)
      else $error("locked otp program not refused");
   chk_otp_exit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cmd_wr && cmd == `CMD_CORE_RST |=> !otp_mode_reg)
      else $error("otp mode kept after reset");
   chk_resume_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::SUSPENDED && cmd_wr && cmd == `CMD_RESUME
      |=> array_block_address_o == $past(erase_addr_reg))
      else $error("resume lost start address");
   chk_erase_ignore: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      core_erase_o && !core_done_i && cmd_wr && cmd == `CMD_OTP |=> !$changed(otp_mode_reg))
      else $error("command taken during erase");
   chk_otp_enter: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::IDLE && cmd_wr && cmd == `CMD_OTP |=> core_otp_sel_o)
      else $error("otp mode not entered");
   chk_page_reserved: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::IDLE && cmd_wr && cmd == `CMD_PROGRAM && otp_mode_reg
      && page_reg > `OTP_USER_LAST |=> err_reg && !core_program_o)
      else $error("reserved otp page programmed");
   chk_no_mb_susp: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      susp_flag_reg && cmd_wr && cmd == `CMD_MB_ERASE |=> state_reg != erase_otp_pkg::MB_LATCH)
      else $error("multi erase accepted while suspended");
   chk_susp_program: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::SUSPENDED && cmd_wr && cmd == `CMD_PROGRAM && !otp_mode_reg
      |=> core_program_o)
      else $error("program refused while suspended");
   chk_prog_back: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      state_reg == erase_otp_pkg::PROGRAMMING && susp_flag_reg && core_done_i
      |=> state_reg == erase_otp_pkg::SUSPENDED)
      else $error("suspension lost after program");
   chk_fail_error: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (core_erase_o || core_program_o) && core_done_i && core_fail_i && !cmd_wr |=> err_reg)
      else $error("core failure not flagged");
   chk_boot_lock: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      boot_reg && lock_word_i[7:0] == `LOCK_PATTERN
      |=> otp_lock_reg && !first_block_locked_flag_reg)
      else $error("lock word not loaded");
   chk_addr_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      busy && wr && paddr == `REG_ADDR |=> addr_reg == $past(addr_reg))
      else $error("address taken while busy");
endmodule

// file: hw/erase_otp_defs.svh
// Purpose: constants for the erase suspend and one-time-programmable block sequencer
// Assumes: 32-bit APB, 125 MHz clock
// Notes:   register offsets are byte addresses
// Behaviour
// - suspend reached within 500 us of suspend command during erase.
// - while suspended, load, program, lock, resets, verify, otp access accepted.
// - while suspended, erase, multi-erase and suspend commands refused.
// - resume restarts the erase from its beginning.
// - address register ignored by suspend and resume.
// - multi-erase suspend/resume only after final 0094h; resume restarts from first block.
// - otp block read, programmed, locked; never erased. A resume after 65h while suspended erases with otp selected.
// - command 65h enters otp mode; load and program go to otp block.
// - cold, warm, hot or core reset leaves otp mode.
// - otp has 64 pages; 0-49 user, 50-63 manufacturer.
// - at power-up, lock word xxfc sets the block-locked flag.
// - program to locked otp refused and error bit set.
// - after lock word programmed and cold reset, status bit 6 set.
// - block lock and first-block lock share one word; three orders valid. The code decodes only xxfc (block lock) and xxf0 (both).
// - during internal erase only reset and suspend are accepted.
// - failure shown on status bit 10 of the status register at f240. The code places the status register at offset 008h.
`ifndef ERASE_OTP_DEFS_SVH
`define ERASE_OTP_DEFS_SVH
`define REG_CMD        12'h000
`define REG_ADDR       12'h004
`define REG_STATUS     12'h008
`define REG_LOCKWORD   12'h00c
`define REG_PAGE       12'h010
`define CMD_ERASE      16'h0094
`define CMD_MB_ERASE   16'h0095
`define CMD_SUSPEND    16'h00b0
`define CMD_RESUME     16'h0030
`define CMD_VERIFY     16'h0071
`define CMD_OTP        16'h0065
`define CMD_LOAD       16'h0000
`define CMD_PROGRAM    16'h0080
`define CMD_CORE_RST   16'h00f0
`define CMD_HOT_RST    16'h00f3
`define CMD_WARM_RST   16'h00f1
`define LOCK_PATTERN   8'hfc
`define LOCK_BOTH      8'hf0
`define ST_ONGO        4'd15
`define ST_ERROR       4'd10
`define ST_OTP_LOCK    4'd6
`define ST_FIRST_LOCK  4'd5
`define ST_SUSPENDED   4'd4
`define ST_OTP_MODE    4'd3
`define OTP_USER_LAST  6'd49
`define SUSPEND_US     500
`define CLK_MHZ        125
`endif

// file: hw/erase_otp_pkg.sv
// Purpose: types for the erase suspend and otp sequencer
// Assumes: nothing
// Notes:   constants live in erase_otp_defs.svh
package erase_otp_pkg;
   typedef enum logic [2:0] {
      IDLE,
      MB_LATCH,
      ERASING,
      SUSPENDING,
      SUSPENDED,
      PROGRAMMING
   } seq_state_type;
endpackage
